// ===== logic/dual_rail_por_bor_wiper_init.sv
// power-on / brown-out sequencer for wiper and terminal control registers
`timescale 1ns/10ps
`default_nettype none
module dual_rail_por_bor_wiper_init (
    input  wire logic       core_clk_in,      // 250 MHz core clock
    input  wire logic       arst_n_in,        // async reset, active low
    input  wire logic       dig_ready_in,     // digital supply above trip point
    input  wire logic       ana_ready_in,     // analog supply valid
    input  wire logic       dig_retain_in,    // digital supply above retention level
    input  wire logic       res_7bit_in,      // high selects the 7-bit variant
    input  wire logic       cmd_valid_in,     // one-cycle command strobe
    input  wire logic [1:0] cmd_op_in,        // command code
    input  wire logic [7:0] cmd_data_in,      // command data
    input  wire logic       cmd_done_in,      // command reached its end
    output logic      [7:0] wiper_reg_out,    // wiper register contents
    output logic      [3:0] terminal_control_reg_out,         // terminal control register
    output logic      [7:0] wiper_pos_out,    // code driven onto the wiper
    output logic            wiper_valid_out,  // analog output is meaningful
    output logic            serial_en_out,    // serial interface enabled
    output logic            regs_defined_out, // register contents trustworthy
    output logic            cmd_aborted_out   // command cut off by brown-out
);
    // =========================================================
    // state
    logic [7:0] wiper;          // volatile wiper register
    logic [7:0] next_wiper;     // its next value
    logic [3:0] terminal_control_reg;           // terminal control register
    logic [3:0] next_terminal_control_reg;      // its next value
    logic       dig_q;          // digital ready last cycle, for edge detect
    logic       next_dig_q;     // its next value
    logic       defined;        // registers hold known contents
    logic       next_defined;   // its next value
    logic       in_cmd;         // a serial command is in progress
    logic       next_in_cmd;    // its next value
    logic       aborted;        // last command was cut off
    logic       next_aborted;   // its next value
    logic [7:0] pos;            // wiper output position
    logic [7:0] next_pos;       // its next value
    logic       pos_valid;      // output position valid
    logic       next_pos_valid; // its next value
    logic       ser_en;         // interface enable
    logic       next_ser_en;    // its next value
    logic       por_event;      // digital supply just came up
    logic       cmd_taken;      // a command is accepted this cycle

    // mid-scale code for the selected resolution
    function automatic logic [7:0] mid_code(input logic is7);
        mid_code = is7 ? por_bor_pkg::MID_SCALE_7BIT : por_bor_pkg::MID_SCALE_8BIT;
    endfunction

    // top code for the selected resolution
    function automatic logic [7:0] top_code(input logic is7);
        top_code = is7 ? por_bor_pkg::FULL_SCALE_7 : por_bor_pkg::FULL_SCALE_8;
    endfunction

    // =========================================================
    // register update logic
    assign por_event = dig_ready_in && !dig_q;
    // power-up edge wins over a strobe in the same cycle, so a command there is dropped
    assign cmd_taken = dig_ready_in && dig_q && cmd_valid_in;

    // next-state of wiper, terminal control and bookkeeping
    always_comb begin
        next_wiper    = wiper;
        next_terminal_control_reg     = terminal_control_reg;
        next_dig_q    = dig_ready_in;
        next_defined  = defined;
        next_in_cmd   = in_cmd;
        next_aborted  = aborted;
        if (!dig_retain_in) begin
            // contents lost; only a fresh init makes them valid again
            next_defined = 1'b0;
        end
        if (por_event) begin
            // analog state deliberately not consulted here
            next_wiper   = mid_code(res_7bit_in);
            next_terminal_control_reg    = por_bor_pkg::TERMINAL_CONTROL_REG_DEFAULT;
            next_defined = 1'b1;
            next_in_cmd  = 1'b0;
        end else if (!dig_ready_in) begin
            // a brown-out mid-command leaves the target suspect
            if (in_cmd) begin
                next_aborted = 1'b1;
            end
            next_in_cmd = 1'b0;
        end else if (cmd_valid_in) begin
            // supply ready: full digital operation, any voltage band
            next_in_cmd  = !cmd_done_in;
            next_aborted = 1'b0;
            unique case (cmd_op_in)
                por_bor_pkg::CMD_WRITE: begin
                    next_wiper = (cmd_data_in > top_code(res_7bit_in)) ?
                                 top_code(res_7bit_in) : cmd_data_in;
                end
                por_bor_pkg::CMD_INCR: begin
                    if (wiper != top_code(res_7bit_in)) begin
                        next_wiper = wiper + 8'h01;
                    end
                end
                por_bor_pkg::CMD_DECR: begin
                    if (wiper != por_bor_pkg::ZERO_SCALE) begin
                        next_wiper = wiper - 8'h01;
                    end
                end
                por_bor_pkg::CMD_TERMINAL_CONTROL_REG: begin
                    next_terminal_control_reg = cmd_data_in[3:0];
                end
            endcase
        end else if (cmd_done_in) begin
            next_in_cmd = 1'b0;
        end
    end

    // registers of the update logic
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wiper   <= por_bor_pkg::MID_SCALE_8BIT;
            terminal_control_reg    <= por_bor_pkg::TERMINAL_CONTROL_REG_DEFAULT;
            dig_q   <= 1'b0;
            defined <= 1'b0;
            in_cmd  <= 1'b0;
            aborted <= 1'b0;
        end else begin
            wiper   <= next_wiper;
            terminal_control_reg    <= next_terminal_control_reg;
            dig_q   <= next_dig_q;
            defined <= next_defined;
            in_cmd  <= next_in_cmd;
            aborted <= next_aborted;
        end
    end

    // =========================================================
    // output source selection
    // both ready: follow register; analog only: forced mid-scale
    always_comb begin
        next_ser_en    = dig_ready_in;
        next_pos_valid = ana_ready_in;
        if (ana_ready_in && dig_ready_in) begin
            next_pos = next_wiper;
        end else begin
            next_pos = mid_code(res_7bit_in);
        end
    end

    // registers of the output selection
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pos       <= por_bor_pkg::MID_SCALE_8BIT;
            pos_valid <= 1'b0;
            ser_en    <= 1'b0;
        end else begin
            pos       <= next_pos;
            pos_valid <= next_pos_valid;
            ser_en    <= next_ser_en;
        end
    end

    assign wiper_reg_out    = wiper;
    assign terminal_control_reg_out         = terminal_control_reg;
    assign wiper_pos_out    = pos;
    assign wiper_valid_out  = pos_valid;
    assign serial_en_out    = ser_en;
    assign regs_defined_out = defined;
    assign cmd_aborted_out  = aborted;

    // =========================================================
    // checks
    por_load_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (dig_ready_in && !dig_q) |=> (wiper == $past(mid_code(res_7bit_in))))
        else $error("wiper not loaded with mid-scale on power-up");
    terminal_control_reg_default_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (dig_ready_in && !dig_q) |=> (terminal_control_reg == por_bor_pkg::TERMINAL_CONTROL_REG_DEFAULT))
        else $error("terminal control not defaulted on power-up");
    analog_indep_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (dig_ready_in && !dig_q && !ana_ready_in) |=> (wiper == $past(mid_code(res_7bit_in))))
        else $error("wiper reset value depended on analog supply");
    forced_mid_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (ana_ready_in && !dig_ready_in) |=> (wiper_pos_out == $past(mid_code(res_7bit_in))))
        else $error("wiper output not forced to mid-scale");
    follow_reg_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (ana_ready_in && dig_ready_in) |=> (wiper_pos_out == wiper_reg_out))
        else $error("wiper output does not follow wiper register");
    cmd_gated_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (!dig_ready_in) |=> $stable(wiper_reg_out))
        else $error("wiper changed while digital supply low");
    serial_off_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (!dig_ready_in) |=> !serial_en_out)
        else $error("serial interface enabled during brown-out");
    retain_lost_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (!dig_retain_in && !(dig_ready_in && !dig_q)) |=> !regs_defined_out)
        else $error("registers still marked defined below retention");
    abort_flag_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (in_cmd && !dig_ready_in && dig_q) |=> cmd_aborted_out)
        else $error("interrupted command not flagged");
    incr_exec_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (dig_ready_in && dig_q && cmd_valid_in && cmd_op_in == por_bor_pkg::CMD_INCR
         && wiper != top_code(res_7bit_in)) |=> (wiper_reg_out == $past(wiper) + 8'h01))
        else $error("increment not executed");
    dig_op_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        dig_ready_in |=> serial_en_out)
        else $error("serial interface off with digital supply ready");

    // =========================================================
    // command execution checks

    // an over-range write lands on the top code of the variant
    write_sat_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (cmd_taken && cmd_op_in == por_bor_pkg::CMD_WRITE && cmd_data_in > top_code(res_7bit_in))
        |=> (wiper_reg_out == $past(top_code(res_7bit_in))))
        else $error("over-range write not saturated");

    // an in-range write lands unchanged
    write_exact_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (cmd_taken && cmd_op_in == por_bor_pkg::CMD_WRITE && cmd_data_in <= top_code(res_7bit_in))
        |=> (wiper_reg_out == $past(cmd_data_in)))
        else $error("in-range write not stored");

    // decrement steps down by one away from zero
    decr_exec_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (cmd_taken && cmd_op_in == por_bor_pkg::CMD_DECR && wiper != por_bor_pkg::ZERO_SCALE)
        |=> (wiper_reg_out == $past(wiper) - 8'h01))
        else $error("decrement not executed");

    // increment at the top code must not wrap
    incr_hold_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (cmd_taken && cmd_op_in == por_bor_pkg::CMD_INCR && wiper == top_code(res_7bit_in))
        |=> $stable(wiper_reg_out))
        else $error("increment wrapped past top code");

    // decrement at zero must not wrap
    decr_hold_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (cmd_taken && cmd_op_in == por_bor_pkg::CMD_DECR && wiper == por_bor_pkg::ZERO_SCALE)
        |=> $stable(wiper_reg_out))
        else $error("decrement wrapped past zero");

    // terminal control write takes the low data nibble
    terminal_control_reg_write_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (cmd_taken && cmd_op_in == por_bor_pkg::CMD_TERMINAL_CONTROL_REG) |=> (terminal_control_reg_out == $past(cmd_data_in[3:0])))
        else $error("terminal control write not stored");

    // terminal control write leaves the wiper alone
    terminal_control_reg_only_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (cmd_taken && cmd_op_in == por_bor_pkg::CMD_TERMINAL_CONTROL_REG) |=> $stable(wiper_reg_out))
        else $error("terminal control write disturbed wiper");

    // wiper commands leave terminal control alone
    wiper_only_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (cmd_taken && cmd_op_in != por_bor_pkg::CMD_TERMINAL_CONTROL_REG) |=> $stable(terminal_control_reg_out))
        else $error("wiper command disturbed terminal control");

    // no terminal control change while the digital rail is down
    terminal_control_reg_gated_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (!dig_ready_in) |=> $stable(terminal_control_reg_out))
        else $error("terminal control changed during brown-out");

    // without a strobe the registers just hold
    idle_hold_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (dig_ready_in && dig_q && !cmd_valid_in) |=> ($stable(wiper_reg_out) && $stable(terminal_control_reg_out)))
        else $error("registers changed without a command");

    // =========================================================
    // output selection and bookkeeping checks

    // a dead analog rail still parks the code at mid-scale
    ana_dead_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (!ana_ready_in) |=> (wiper_pos_out == $past(mid_code(res_7bit_in))))
        else $error("wiper output not parked with analog rail down");

    // power-up with analog ready shows the fresh mid-scale at once
    por_pos_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (por_event && ana_ready_in) |=> (wiper_pos_out == $past(mid_code(res_7bit_in))))
        else $error("wiper output missed power-up value");

    // output validity follows the analog rail one cycle late
    valid_track_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        1'b1 |=> (wiper_valid_out == $past(ana_ready_in)))
        else $error("wiper valid does not track analog rail");

    // a power-up makes the contents trustworthy again
    defined_set_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        por_event |=> regs_defined_out)
        else $error("registers not marked defined after power-up");

    // an accepted command clears the abort mark
    abort_clear_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        cmd_taken |=> !cmd_aborted_out)
        else $error("abort mark survived a new command");

    // a brown-out with nothing open keeps the abort mark as it was
    abort_hold_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (!dig_ready_in && !in_cmd) |=> (cmd_aborted_out == $past(aborted)))
        else $error("abort mark changed with no open command");

    // a strobe without its end leaves the command open
    cmd_open_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (cmd_taken && !cmd_done_in) |=> in_cmd)
        else $error("open command not tracked");

    // brown-out always closes any open command
    cmd_close_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (!dig_ready_in) |=> !in_cmd)
        else $error("command left open during brown-out");

    // power-up never inherits an open command
    por_cmd_drop_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        por_event |=> !in_cmd)
        else $error("open command survived power-up");
endmodule // dual_rail_por_bor_wiper_init
`default_nettype wire

// ===== logic/por_bor_pkg.sv
// constants for the dual-rail power-on / brown-out wiper initialiser
`default_nettype none
package por_bor_pkg;
    // =========================================================
    // widths and reset values
    localparam int unsigned WIPER_W        = 8;        // widest variant
    localparam int unsigned TERMINAL_CONTROL_REG_W         = 4;        // terminal control bits
    localparam logic [7:0]  MID_SCALE_8BIT = 8'h7f;    // 8-bit mid-scale
    localparam logic [7:0]  MID_SCALE_7BIT = 8'h3f;    // 7-bit mid-scale
    localparam logic [7:0]  FULL_SCALE_8   = 8'hff;    // 8-bit top code
    localparam logic [7:0]  FULL_SCALE_7   = 8'h7f;    // 7-bit top code
    localparam logic [7:0]  ZERO_SCALE     = 8'h00;    // bottom code
    localparam logic [3:0]  TERMINAL_CONTROL_REG_DEFAULT   = 4'hf;     // all terminals connected
    // =========================================================
    // command encodings
    localparam logic [1:0]  CMD_WRITE      = 2'h0;     // write wiper
    localparam logic [1:0]  CMD_INCR       = 2'h1;     // increment wiper
    localparam logic [1:0]  CMD_DECR       = 2'h2;     // decrement wiper
    localparam logic [1:0]  CMD_TERMINAL_CONTROL_REG       = 2'h3;     // write terminal control
endpackage : por_bor_pkg
`default_nettype wire

// ===== verif/supply_host_model.sv
// supply detectors and command host that drive the sequencer inputs
`timescale 1ns/10ps
`default_nettype none
module supply_host_model (
    input  wire logic       clk_in,        // core clock
    output logic            dig_ok_out,    // digital supply ready
    output logic            ana_ok_out,    // analog supply ready
    output logic            retain_out,    // above retention level
    output logic            res7_out,      // 7-bit variant strap
    output logic            valid_out,     // command strobe
    output logic      [1:0] op_out,        // command code
    output logic      [7:0] data_out,      // command data
    output logic            done_out       // command end marker
);
    // ==========================================
    // everything starts powered down and idle
    initial begin
        {dig_ok_out, ana_ok_out, retain_out, res7_out} = 4'h0;
        {valid_out, done_out, op_out, data_out} = 12'h000;
    end
    // supply levels move just after an edge, like a slow detector
    task automatic set_supply(input logic d, input logic a, input logic r, input logic v7);
        @(posedge clk_in);
        dig_ok_out <= d;
        ana_ok_out <= a;
        retain_out <= r;
        res7_out   <= v7;
    endtask
    // one-cycle strobe; done low leaves the command open
    task automatic send(input logic [1:0] op, input logic [7:0] data, input logic done);
        @(posedge clk_in);
        valid_out <= 1'b1;
        op_out    <= op;
        data_out  <= data;
        done_out  <= done;
        @(posedge clk_in);
        valid_out <= 1'b0;
        done_out  <= 1'b0;
        data_out  <= ~data; // no stale data after the strobe
    endtask
endmodule // supply_host_model
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the power-on / brown-out wiper sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic       core_clk;            // 250 MHz clock
    logic       arst_n;              // async reset, active low
    logic       dig_ok, ana_ok, retain, res7, valid, done;
    logic [1:0] op;                  // command code
    logic [7:0] data, wiper_reg, pos, keep;
    logic [3:0] terminal_control_reg;                // terminal control
    logic       wvalid, serial_en, defined, aborted;
    int         errors = 0;
    int         samples_checked = 0;
    int         cycles = 0;          // timeout counter
    // ==========================================
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    supply_host_model host (.clk_in(core_clk), .dig_ok_out(dig_ok), .ana_ok_out(ana_ok), .retain_out(retain),
        .res7_out(res7), .valid_out(valid), .op_out(op), .data_out(data), .done_out(done));
    dual_rail_por_bor_wiper_init u_dut (.core_clk_in(core_clk), .arst_n_in(arst_n), .dig_ready_in(dig_ok),
        .ana_ready_in(ana_ok), .dig_retain_in(retain), .res_7bit_in(res7), .cmd_valid_in(valid),
        .cmd_op_in(op), .cmd_data_in(data), .cmd_done_in(done), .wiper_reg_out(wiper_reg), .terminal_control_reg_out(terminal_control_reg),
        .wiper_pos_out(pos), .wiper_valid_out(wvalid), .serial_en_out(serial_en),
        .regs_defined_out(defined), .cmd_aborted_out(aborted));
    // a hang is cut short well past the fifty or so cycles needed
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            summarize();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic settle();
        @(posedge core_clk);
        #1;
    endtask
    task automatic summarize();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================================
    // digital rail first, analog rail still dead
    task automatic t_power_up();
        host.set_supply(1'b1, 1'b0, 1'b1, 1'b0);
        settle();
        check(wiper_reg, 8'h7f);
        check({4'h0, terminal_control_reg}, 8'h0f);
        check({7'h0, wvalid}, 8'h00);
        check({7'h0, serial_en}, 8'h01);
        host.set_supply(1'b1, 1'b1, 1'b1, 1'b0);
        settle();
        check({wvalid, pos[6:0]}, 8'hff);
    endtask
    task automatic t_commands();
        host.send(por_bor_pkg::CMD_WRITE, 8'h20, 1'b1);
        #1 check(wiper_reg, 8'h20);
        check(pos, 8'h20);
        host.send(por_bor_pkg::CMD_INCR, 8'h00, 1'b1);
        #1 check(wiper_reg, 8'h21);
        host.send(por_bor_pkg::CMD_DECR, 8'h00, 1'b1);
        #1 check(wiper_reg, 8'h20);
        host.send(por_bor_pkg::CMD_TERMINAL_CONTROL_REG, 8'h05, 1'b1);
        #1 check({4'h0, terminal_control_reg}, 8'h05);
    endtask
    // 7-bit part: saturation and both end stops
    task automatic t_limits();
        host.send(por_bor_pkg::CMD_WRITE, 8'hff, 1'b1);
        #1 check(wiper_reg, 8'h7f);
        check(pos, 8'h7f);
        host.send(por_bor_pkg::CMD_INCR, 8'h00, 1'b1);
        #1 check(wiper_reg, 8'h7f);
        host.send(por_bor_pkg::CMD_WRITE, 8'h00, 1'b1);
        #1 check(wiper_reg, 8'h00);
        host.send(por_bor_pkg::CMD_DECR, 8'h00, 1'b1);
        #1 check(wiper_reg, 8'h00);
    endtask
    // brown-out cuts an open command, then recovery as 7-bit part
    task automatic t_brown_out();
        host.send(por_bor_pkg::CMD_WRITE, 8'h40, 1'b0);
        host.set_supply(1'b0, 1'b1, 1'b1, 1'b0);
        settle();
        check({6'h0, serial_en, aborted}, 8'h01);
        check(pos, 8'h7f);
        keep = wiper_reg;
        host.send(por_bor_pkg::CMD_WRITE, 8'h55, 1'b1);
        #1 check(wiper_reg, keep);
        host.set_supply(1'b0, 1'b1, 1'b0, 1'b1);
        settle();
        check({7'h0, defined}, 8'h00);
        host.set_supply(1'b1, 1'b1, 1'b1, 1'b1);
        settle();
        check(wiper_reg, 8'h3f);
        check(pos, 8'h3f);
        check({3'h0, defined, terminal_control_reg}, 8'h1f);
        host.send(por_bor_pkg::CMD_INCR, 8'h00, 1'b1);
        #1 check({aborted, wiper_reg[6:0]}, 8'h40);
    endtask
    initial begin
        arst_n = 1'b0;
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_power_up();
        t_commands();
        t_brown_out();
        t_limits();
        summarize();
    end
endmodule // testbench
`default_nettype wire
